// file: hdl/tsp_pkg.sv
// Summary of operation
// - Static fields read on load, never written
// - Dynamic fields read on load, written on suspend
// - Switch touches only first 104 bytes, 108 with shadow stacks
// - Task register load touches no block field
// - Back-link selector at bytes 01h-00h, dynamic
// - Stack selector/offset pairs at 1Bh-04h, static
// - Page table base at 1Fh-1Ch, static
// - Instruction pointer and flags are dynamic
// - GPRs 47h-28h, selectors 5Fh-48h dynamic
// - Descriptor table selector at 63h-60h static
// - Trap bit set raises debug exception
// - Shadow stack pointer loaded, never stored
// - Bitmap base offset at bytes 67h-66h
// - Check bitmap in v86 or low privilege
// - All covered bits clear else fault
// - Base above 0DFFFh faults bitmap accesses
// - Always fetch two consecutive bitmap bytes
// - Bits beyond block limit count as set
// - Redirect bitmap 256 bits, 32 bytes
// - Small limit raises invalid-state exception
package tsp_pkg;
	// ****************************************
	// Field offsets within the state block
	// ****************************************
	localparam logic [15:0] TSP_OFF_LINK = 16'h0000;
	localparam logic [15:0] TSP_OFF_STK = 16'h0004;
	localparam logic [15:0] TSP_OFF_PTB = 16'h001C;
	localparam logic [15:0] TSP_OFF_NIP = 16'h0020;
	localparam logic [15:0] TSP_OFF_FLG = 16'h0024;
	localparam logic [15:0] TSP_OFF_GPR = 16'h0028;
	localparam logic [15:0] TSP_OFF_SEL = 16'h0048;
	localparam logic [15:0] TSP_OFF_LDT = 16'h0060;
	localparam logic [15:0] TSP_OFF_TRAP = 16'h0064;
	localparam logic [15:0] TSP_OFF_SSP = 16'h0068;
	localparam int TSP_TRAP_BIT = 0;
	localparam int TSP_BMB_LSB = 16;
	localparam logic [15:0] TSP_MIN_LIMIT = 16'h0067;
	localparam logic [15:0] TSP_MIN_LIMIT_SS = 16'h006B;
	localparam logic [15:0] TSP_BMB_MAX = 16'hDFFF;
	localparam logic [15:0] TSP_IRB_BYTES = 16'h0020;
	localparam int TSP_NSTK = 3;
	localparam int TSP_NGPR = 8;
	localparam int TSP_NSEL = 6;
	localparam logic [4:0] TSP_LOAD_WORDS = 5'h1A;
	localparam logic [4:0] TSP_LOAD_WORDS_SS = 5'h1B;
	localparam logic [4:0] TSP_SAVE_FIRST = 5'h08;
	localparam logic [4:0] TSP_SAVE_LAST = 5'h17;

	typedef enum logic [2:0] {
		TSP_IDLE = 3'b000,
		TSP_CHECK = 3'b001,
		TSP_SAVE = 3'b010,
		TSP_LOAD = 3'b011,
		TSP_IO_RD0 = 3'b100,
		TSP_IO_RD1 = 3'b101,
		TSP_IRB_RD = 3'b110,
		TSP_DONE = 3'b111
	} tsp_state_t;
endpackage

// file: hdl/tsp_task_state_io_permission.sv
module tsp_task_state_io_permission import tsp_pkg::*; (
	input wire logic mclk,
	input wire logic arst_n,
	// Task switch request with outgoing context
	input wire logic switch_req,
	input wire logic [31:0] new_block_base,
	input wire logic [15:0] new_block_limit,
	input wire logic [15:0] new_selector,
	input wire logic shadow_stack_en,
	input wire logic [31:0] cur_next_instruction_pointer,
	input wire logic [31:0] cur_flags_image,
	input wire logic [255:0] cur_gpr,
	input wire logic [95:0] cur_sel,
	// Task register load instruction
	input wire logic task_register_load_instr,
	input wire logic [31:0] ltr_base,
	input wire logic [15:0] ltr_limit,
	input wire logic [15:0] ltr_selector,
	// Port check and redirect lookup
	input wire logic io_req,
	input wire logic [15:0] io_port,
	input wire logic [2:0] io_size,
	input wire logic v86_mode,
	input wire logic [1:0] current_privilege_level,
	input wire logic [1:0] io_privilege_level,
	input wire logic irq_req,
	input wire logic [7:0] irq_vector,
	// Memory port to the state block
	output logic mem_rd,
	output logic mem_wr,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	// Results
	output logic busy,
	output logic done,
	output logic general_protection_fault,
	output logic invalid_state_exception,
	output logic debug_exception,
	output logic irq_redirect,
	output logic [15:0] task_pointer_register,
	output logic [31:0] block_base_out,
	output logic [15:0] block_limit_out,
	output logic task_busy_mark,
	output logic [15:0] back_link,
	output logic [31:0] page_table_base,
	output logic [31:0] next_instruction_pointer,
	output logic [31:0] flags_image,
	output logic [255:0] gpr_out,
	output logic [95:0] sel_out,
	output logic [15:0] local_descriptor_table,
	output logic [95:0] stack_offset,
	output logic [47:0] stack_segment_selector,
	output logic [31:0] shadow_stack_pointer
);
	// ****************************************
	// Reset release
	// ****************************************
	logic rst_s1_reg, rst_n_reg;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_reg <= rst_s1_reg;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	tsp_state_t state_reg;
	logic [4:0] word_reg;
	logic [15:0] prev_sel_reg;
	logic [31:0] old_base_reg;
	logic [15:0] new_sel_reg;
	logic [31:0] nb_reg;
	logic [15:0] nl_reg;
	logic [31:0] wdata_next;
	logic [16:0] bit_idx;
	logic [16:0] byte_off;
	logic [16:0] byte_off2;
	logic [15:0] bmb_reg;
	logic [7:0] byte0_reg;
	logic [6:0] mask;
	logic [14:0] chk;
	logic [2:0] bitpos_reg;
	logic [2:0] size_reg;
	logic [7:0] vec_reg;
	logic fault_next;
	logic [4:0] load_words;
	// Port number held for the whole bitmap walk
	logic [15:0] port_reg;

	assign load_words = shadow_stack_en ? TSP_LOAD_WORDS_SS : TSP_LOAD_WORDS;

	// Word index to save value: only dynamic fields
	always_comb begin
		wdata_next = 32'h00000000;
		if (word_reg == 5'h08)
			wdata_next = cur_next_instruction_pointer;
		else if (word_reg == 5'h09)
			wdata_next = cur_flags_image;
		else if (word_reg >= 5'h0A && word_reg <= 5'h11)
			wdata_next = cur_gpr[(32'(word_reg) - 10) * 32 +: 32];
		else if (word_reg >= 5'h12)
			wdata_next = {16'h0000, cur_sel[(32'(word_reg) - 18) * 16 +: 16]};
	end

	// bit index = port, byte offset = base + port/8
	assign bit_idx = {1'b0, io_port};
	assign byte_off = 17'(bmb_reg) + 17'(port_reg[15:3]);
	assign byte_off2 = byte_off + 17'h00001;
	assign chk = 15'({mem_rdata[7:0], byte0_reg} >> bitpos_reg);
	assign mask = (size_reg == 3'h4) ? 7'h0F : (size_reg == 3'h2) ? 7'h03 : 7'h01;

	always_comb begin
		fault_next = |(chk[6:0] & mask);
		if (byte_off2 > 17'(nl_reg))
			fault_next = 1'b1;
	end

	always_ff @(posedge mclk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			state_reg <= TSP_IDLE;
			word_reg <= 5'h00;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_addr <= 32'h00000000;
			mem_wdata <= 32'h00000000;
			busy <= 1'b0;
			done <= 1'b0;
			general_protection_fault <= 1'b0;
			invalid_state_exception <= 1'b0;
			debug_exception <= 1'b0;
			irq_redirect <= 1'b0;
			task_pointer_register <= 16'h0000;
			block_base_out <= 32'h00000000;
			block_limit_out <= 16'h0000;
			task_busy_mark <= 1'b0;
			prev_sel_reg <= 16'h0000;
			old_base_reg <= 32'h00000000;
			new_sel_reg <= 16'h0000;
			nb_reg <= 32'h00000000;
			nl_reg <= 16'h0000;
			bmb_reg <= 16'h0000;
			byte0_reg <= 8'h00;
			bitpos_reg <= 3'h0;
			size_reg <= 3'h0;
			vec_reg <= 8'h00;
			port_reg <= 16'h0000;
		end else begin
			done <= 1'b0;
			general_protection_fault <= 1'b0;
			invalid_state_exception <= 1'b0;
			debug_exception <= 1'b0;
			irq_redirect <= 1'b0;
			task_busy_mark <= 1'b0;
			case (state_reg)
				TSP_IDLE: begin
					if (task_register_load_instr) begin
						task_pointer_register <= ltr_selector;
						block_base_out <= ltr_base;
						block_limit_out <= ltr_limit;
						nl_reg <= ltr_limit;
						task_busy_mark <= 1'b1;
						done <= 1'b1;
					end else if (switch_req) begin
						busy <= 1'b1;
						old_base_reg <= block_base_out;
						prev_sel_reg <= task_pointer_register;
						new_sel_reg <= new_selector;
						nb_reg <= new_block_base;
						nl_reg <= new_block_limit;
						state_reg <= TSP_CHECK;
					end else if (io_req) begin
						if (v86_mode || current_privilege_level > io_privilege_level) begin
							busy <= 1'b1;
							size_reg <= io_size;
							port_reg <= io_port;
							bitpos_reg <= bit_idx[2:0];
							mem_rd <= 1'b1;
							mem_addr <= block_base_out + 32'(TSP_OFF_TRAP);
							state_reg <= TSP_IO_RD0;
							word_reg <= 5'h00;
						end else begin
							done <= 1'b1;
						end
					end else if (irq_req) begin
						busy <= 1'b1;
						vec_reg <= irq_vector;
						mem_rd <= 1'b1;
						mem_addr <= block_base_out + 32'(TSP_OFF_TRAP);
						word_reg <= 5'h01;
						state_reg <= TSP_IO_RD0;
					end
				end
				TSP_CHECK: begin
					if (nl_reg < (shadow_stack_en ? TSP_MIN_LIMIT_SS : TSP_MIN_LIMIT)) begin
						invalid_state_exception <= 1'b1;
						state_reg <= TSP_DONE;
					end else begin
						word_reg <= TSP_SAVE_FIRST;
						state_reg <= TSP_SAVE;
					end
				end
				TSP_SAVE: begin
					if (!mem_wr) begin
						mem_wr <= 1'b1;
						mem_addr <= old_base_reg + {25'h0000000, word_reg, 2'b00};
						mem_wdata <= wdata_next;
					end else if (mem_ack) begin
						mem_wr <= 1'b0;
						if (word_reg == TSP_SAVE_LAST) begin
							word_reg <= 5'h00;
							state_reg <= TSP_LOAD;
						end else begin
							word_reg <= word_reg + 5'h01;
						end
					end
				end
				TSP_LOAD: begin
					if (!mem_rd) begin
						mem_rd <= 1'b1;
						mem_addr <= nb_reg + {25'h0000000, word_reg, 2'b00};
					end else if (mem_ack) begin
						mem_rd <= 1'b0;
						if (word_reg == TSP_OFF_TRAP[6:2] && mem_rdata[TSP_TRAP_BIT])
							debug_exception <= 1'b1;
						if (word_reg == load_words - 5'h01) begin
							task_pointer_register <= new_sel_reg;
							block_base_out <= nb_reg;
							block_limit_out <= nl_reg;
							task_busy_mark <= 1'b1;
							state_reg <= TSP_DONE;
						end else begin
							word_reg <= word_reg + 5'h01;
						end
					end
				end
				TSP_IO_RD0: begin
					if (mem_ack) begin
						bmb_reg <= mem_rdata[TSP_BMB_LSB +: 16];
						if (word_reg == 5'h01) begin
							mem_addr <= block_base_out + 32'(mem_rdata[31:16]) - 32'(TSP_IRB_BYTES)
								+ 32'(vec_reg[7:3]);
							state_reg <= TSP_IRB_RD;
						end else if (mem_rdata[31:16] > TSP_BMB_MAX) begin
							mem_rd <= 1'b0;
							general_protection_fault <= 1'b1;
							state_reg <= TSP_DONE;
						end else begin
							mem_addr <= block_base_out + 32'(mem_rdata[31:16]) + 32'(port_reg[15:3]);
							state_reg <= TSP_IO_RD1;
							word_reg <= 5'h02;
						end
					end
				end
				TSP_IO_RD1: begin
					if (mem_ack) begin
						if (word_reg == 5'h02) begin
							byte0_reg <= mem_rdata[7:0];
							mem_addr <= mem_addr + 32'h00000001;
							word_reg <= 5'h03;
						end else begin
							mem_rd <= 1'b0;
							general_protection_fault <= fault_next;
							state_reg <= TSP_DONE;
						end
					end
				end
				TSP_IRB_RD: begin
					if (mem_ack) begin
						mem_rd <= 1'b0;
						irq_redirect <= mem_rdata[vec_reg[2:0]];
						state_reg <= TSP_DONE;
					end
				end
				TSP_DONE: begin
					busy <= 1'b0;
					done <= 1'b1;
					state_reg <= TSP_IDLE;
				end
				default: state_reg <= TSP_IDLE;
			endcase
		end
	end

	// ****************************************
	// Loaded context capture
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			back_link <= 16'h0000;
			page_table_base <= 32'h00000000;
			next_instruction_pointer <= 32'h00000000;
			flags_image <= 32'h00000000;
			gpr_out <= '0;
			sel_out <= '0;
			local_descriptor_table <= 16'h0000;
			stack_offset <= '0;
			stack_segment_selector <= '0;
			shadow_stack_pointer <= 32'h00000000;
		end else if (state_reg == TSP_LOAD && mem_rd && mem_ack) begin
			case (word_reg)
				5'h00: back_link <= prev_sel_reg;
				5'h01, 5'h03, 5'h05:
					stack_offset[(32'(word_reg) - 1) * 16 +: 32] <= mem_rdata;
				5'h02, 5'h04, 5'h06:
					stack_segment_selector[(32'(word_reg) - 2) * 8 +: 16] <= mem_rdata[15:0];
				5'h07: page_table_base <= mem_rdata;
				5'h08: next_instruction_pointer <= mem_rdata;
				5'h09: flags_image <= mem_rdata;
				5'h18: local_descriptor_table <= mem_rdata[15:0];
				5'h1A: shadow_stack_pointer <= mem_rdata;
				default: begin
					if (word_reg >= 5'h0A && word_reg <= 5'h11)
						gpr_out[(32'(word_reg) - 10) * 32 +: 32] <= mem_rdata;
					else if (word_reg >= 5'h12 && word_reg <= 5'h17)
						sel_out[(32'(word_reg) - 18) * 16 +: 16] <= mem_rdata[15:0];
				end
			endcase
		end
	end
endmodule

// file: dv/tsp_mem_model.sv
module tsp_mem_model (
	input wire logic mclk,
	input wire logic rd,
	input wire logic wr,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic [1:0] dly,
	output logic [31:0] rdata,
	output logic ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] m [int unsigned];
	logic [31:0] last = 32'h0;
	int n = 0;
	function automatic logic [7:0] b(int unsigned a);
		return m.exists(a) ? m[a] : 8'h00;
	endfunction
	// Every access is answered after dly cycles and never faults mid-switch
	// Released data bus shows the inverse of the last word
	always @(posedge mclk) begin
		ack <= 1'b0;
		rdata <= ~last;
		if ((rd || wr) && !ack) begin
			if (n == int'(dly)) begin
				n = 0;
				ack <= 1'b1;
				if (wr) for (int i = 0; i < 4; i++) m[addr + i] = wdata[8*i +: 8];
				last = {b(addr + 3), b(addr + 2), b(addr + 1), b(addr)};
				rdata <= last;
			end else n++;
		end
	end
endmodule

// file: dv/tsp_task_state_io_permission_asserts.sv
module tsp_task_state_io_permission_asserts import tsp_pkg::*; (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic switch_req,
	input wire logic [15:0] new_block_limit,
	input wire logic shadow_stack_en,
	input wire logic [31:0] cur_next_instruction_pointer,
	input wire logic task_register_load_instr,
	input wire logic io_req,
	input wire logic v86_mode,
	input wire logic [1:0] current_privilege_level,
	input wire logic [1:0] io_privilege_level,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic busy,
	input wire logic done,
	input wire logic general_protection_fault,
	input wire logic invalid_state_exception,
	input wire logic debug_exception,
	input wire logic task_busy_mark,
	input wire logic [31:0] block_base_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	logic [31:0] off;
	assign off = mem_addr - block_base_out;
	sequence s_quiet_done;
		done && !mem_rd && !mem_wr;
	endsequence
	property p_save_range;
		mem_wr |-> off >= 32'h20 && off <= 32'h5C;
	endproperty
	a_save_range: assert property (p_save_range) else $error("write outside dynamic fields");
	property p_nip_save;
		mem_wr && off == 32'h20 |-> mem_wdata == cur_next_instruction_pointer;
	endproperty
	a_nip_save: assert property (p_nip_save) else $error("wrong saved pointer");
	property p_load_quiet;
		task_register_load_instr && !busy |=> s_quiet_done;
	endproperty
	a_load_quiet: assert property (p_load_quiet) else $error("register load touched memory");
	property p_busy_mark;
		task_register_load_instr && !busy |=> task_busy_mark;
	endproperty
	a_busy_mark: assert property (p_busy_mark) else $error("register load did not mark task busy");
	property p_io_skip;
		io_req && !busy && !task_register_load_instr && !switch_req && !v86_mode &&
			current_privilege_level <= io_privilege_level |=> s_quiet_done;
	endproperty
	a_io_skip: assert property (p_io_skip) else $error("bitmap read when not needed");
	property p_gp_done;
		general_protection_fault |=> done;
	endproperty
	a_gp_done: assert property (p_gp_done) else $error("fault not followed by done");
	property p_hold;
		(mem_rd || mem_wr) && !mem_ack |=> (mem_rd || mem_wr) && $stable(mem_addr);
	endproperty
	a_hold: assert property (p_hold) else $error("request dropped before ack");
	property p_small;
		switch_req && !busy && !task_register_load_instr &&
			new_block_limit < (shadow_stack_en ? TSP_MIN_LIMIT_SS : TSP_MIN_LIMIT) |-> ##[1:4] invalid_state_exception;
	endproperty
	a_small: assert property (p_small) else $error("small limit accepted");
	property p_dbg;
		debug_exception |-> busy && !mem_wr;
	endproperty
	a_dbg: assert property (p_dbg) else $error("debug exception out of load");
endmodule

// file: dv/test_task_state_io_permission.sv
module test_task_state_io_permission import tsp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, arst_n = 0, switch_req = 0, shadow_stack_en = 0, task_register_load_instr = 0;
	logic io_req = 0, v86_mode = 0, irq_req = 0, mem_rd, mem_wr, mem_ack, busy, done, gp, ise, dbe, red;
	logic general_protection_fault, invalid_state_exception, debug_exception, irq_redirect, task_busy_mark;
	logic [31:0] new_block_base = 0, ltr_base = 0, cur_next_instruction_pointer = 0, cur_flags_image = 0;
	logic [31:0] mem_addr, mem_wdata, mem_rdata, block_base_out, page_table_base, next_instruction_pointer;
	logic [31:0] flags_image, shadow_stack_pointer, rs = 32'd69185;
	logic [15:0] new_block_limit = 0, new_selector = 0, ltr_limit = 0, ltr_selector = 0, io_port = 0;
	logic [15:0] task_pointer_register, block_limit_out, back_link, local_descriptor_table;
	logic [255:0] cur_gpr = 0, gpr_out;
	logic [95:0] cur_sel = 0, sel_out, stack_offset;
	logic [47:0] stack_segment_selector;
	logic [2:0] io_size = 3'h1;
	logic [1:0] current_privilege_level = 0, io_privilege_level = 0, dly = 0;
	logic [7:0] irq_vector = 0;
	int fails = 0, samples_checked = 0, k;
	localparam int OP_LOAD = 0, OP_SWITCH = 1, OP_IO = 2, OP_IRQ = 3;
	tsp_task_state_io_permission DUT (.*);
	tsp_mem_model mem (.mclk, .rd(mem_rd), .wr(mem_wr), .addr(mem_addr), .wdata(mem_wdata), .dly,
		.rdata(mem_rdata), .ack(mem_ack));
	always #12.5 mclk = ~mclk;
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function automatic logic [31:0] w(int unsigned a);
		return {mem.b(a + 3), mem.b(a + 2), mem.b(a + 1), mem.b(a)};
	endfunction
	function automatic logic exp_gp(logic [15:0] bmb, logic [15:0] lim);
		logic [15:0] o;
		logic [15:0] bits;
		o = bmb + (io_port >> 3);
		bits = {mem.b(32'h3000 + o + 1), mem.b(32'h3000 + o)} >> io_port[2:0];
		if (!v86_mode && current_privilege_level <= io_privilege_level) return 1'b0;
		return bmb > TSP_BMB_MAX || o + 16'h1 > lim || (bits & ((16'h1 << io_size) - 16'h1)) != 16'h0;
	endfunction
	task automatic put(int unsigned a, logic [31:0] v);
		for (int i = 0; i < 4; i++) mem.m[a + i] = v[8*i +: 8];
	endtask
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One request strobe for one cycle, then gather result pulses up to done
	task automatic op(int c);
		@(posedge mclk);
		{irq_req, io_req, switch_req, task_register_load_instr} <= 4'(1 << c);
		dly <= 2'(rnd());
		@(posedge mclk);
		{irq_req, io_req, switch_req, task_register_load_instr} <= 4'h0;
		{gp, ise, dbe, red} = 4'h0;
		k = 0;
		do begin
			#1;
			{gp, ise, dbe, red} = {gp, ise, dbe, red} |
				{general_protection_fault, invalid_state_exception, debug_exception, irq_redirect};
			k++;
			if (done !== 1'b1) @(posedge mclk);
		end while (done !== 1'b1 && k < 300);
		if (k >= 300) chk(32'h0, 32'h1);
		@(posedge mclk);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#500000;
		fails++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		// ****************
		// Register load, then a full switch
		// ****************
		ltr_base <= 32'h1000;
		ltr_limit <= 16'h00FF;
		ltr_selector <= 16'h0028;
		put(32'h101C, 32'hC3C30001);
		put(32'h1068, 32'h5A5A0002);
		op(OP_LOAD);
		chk(32'(task_pointer_register), 32'h0028);
		chk(block_base_out, 32'h1000);
		chk(32'(block_limit_out), 32'h00FF);
		for (int a = 0; a < 32'h6C; a += 4) put(32'h2000 + a, rnd());
		mem.m[32'h2064] = 8'h01;
		cur_next_instruction_pointer <= rnd();
		cur_flags_image <= rnd();
		for (int i = 0; i < 8; i++) cur_gpr[32*i +: 32] <= rnd();
		for (int i = 0; i < 6; i++) cur_sel[16*i +: 16] <= 16'(rnd());
		new_block_base <= 32'h2000;
		new_block_limit <= 16'h00FF;
		new_selector <= 16'h0030;
		shadow_stack_en <= 1'b1;
		op(OP_SWITCH);
		chk(32'(dbe), 32'h1);
		chk(32'(ise), 32'h0);
		chk(page_table_base, w(32'h201C));
		chk(stack_offset[31:0], w(32'h2004));
		chk(32'(stack_segment_selector[15:0]), w(32'h2008) & 32'h0000FFFF);
		chk(next_instruction_pointer, w(32'h2020));
		chk(flags_image, w(32'h2024));
		chk(gpr_out[255:224], w(32'h2044));
		chk(32'(sel_out[95:80]), w(32'h205C) & 32'h0000FFFF);
		chk(32'(sel_out[15:0]), w(32'h2048) & 32'h0000FFFF);
		chk(32'(local_descriptor_table), w(32'h2060) & 32'h0000FFFF);
		chk(shadow_stack_pointer, w(32'h2068));
		chk(32'(back_link), 32'h0028);
		chk(w(32'h1020), cur_next_instruction_pointer);
		chk(w(32'h1024), cur_flags_image);
		chk(w(32'h1044), cur_gpr[255:224]);
		chk(w(32'h105C), 32'(cur_sel[95:80]));
		chk(w(32'h101C), 32'hC3C30001);
		chk(w(32'h1068), 32'h5A5A0002);
		// Switch without shadow stacks: the pointer word is left alone
		for (int a = 0; a < 32'h68; a += 4) put(32'h2100 + a, rnd());
		mem.m[32'h2164] = 8'h00;
		put(32'h2168, 32'hA5A5A5A5);
		new_block_base <= 32'h2100;
		new_block_limit <= 16'h0067;
		new_selector <= 16'h0038;
		shadow_stack_en <= 1'b0;
		op(OP_SWITCH);
		chk(32'(dbe), 32'h0);
		chk(32'(ise), 32'h0);
		chk(shadow_stack_pointer, w(32'h2068));
		chk(32'(local_descriptor_table), w(32'h2160) & 32'h0000FFFF);
		chk(32'(back_link), 32'h0030);
		chk(w(32'h2020), cur_next_instruction_pointer);
		for (int s = 0; s < 2; s++) begin
			shadow_stack_en <= s[0];
			new_block_limit <= s[0] ? 16'h006A : 16'h0066;
			op(OP_SWITCH);
			chk(32'(ise), 32'h1);
		end
		$display("switch tests done");
		// ****************
		// Port checks and redirect lookups
		// ****************
		ltr_base <= 32'h3000;
		ltr_limit <= 16'h00A0;
		op(OP_LOAD);
		for (int a = 32'h3068; a < 32'h30A0; a++) mem.m[a] = 8'(rnd());
		mem.m[32'h30A0] = 8'hFF;
		put(32'h3064, 32'h00880000);
		for (int i = 0; i < 48; i++) begin
			{v86_mode, current_privilege_level, io_privilege_level} <= 5'(rnd());
			io_port <= i < 6 ? 16'h00BE + 16'(i) : 16'(rnd() % 256);
			io_size <= 3'(1 << (rnd() % 3));
			op(OP_IO);
			chk(32'(gp), 32'(exp_gp(16'h0088, 16'h00A0)));
		end
		put(32'h3064, 32'hE0000000);
		v86_mode <= 1'b1;
		op(OP_IO);
		chk(32'(gp), 32'h1);
		put(32'h3064, 32'h00880000);
		for (int i = 0; i < 8; i++) begin
			irq_vector <= i == 0 ? 8'hFF : 8'(rnd());
			op(OP_IRQ);
			chk(32'(red), 32'(mem.b(32'h3068 + irq_vector / 8) >> irq_vector[2:0]) & 32'h1);
		end
		$display("port tests done");
		tally_and_finish();
	end
endmodule
bind tsp_task_state_io_permission tsp_task_state_io_permission_asserts u_chk (.*);
